// ==== rtl/acr_top.sv ====
// converter control, result and compare registers behind an AXI4-Lite slave
`timescale 1ns/1ns
module acr_top
	import acr_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [ACR_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [ACR_DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ACR_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [ACR_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  hw_trigger_in,
	input  wire acr_conv_rsp_t         conv_rsp,
	output acr_conv_req_t              conv_req,
	output logic                       complete_irq
);
	// register index decode, shared by read and write paths
	function automatic logic [2:0] reg_sel(input logic [ACR_ADDR_W-1:0] a);
		logic [2:0] s;
		s = 3'h7;
		if (a[1:0] == 2'h0) begin
			unique case (a)
				ACR_OFF_SC1:    s = 3'h0;
				ACR_OFF_SC2:    s = 3'h1;
				ACR_OFF_RES_HI: s = 3'h2;
				ACR_OFF_RES_LO: s = 3'h3;
				ACR_OFF_CV_HI:  s = 3'h4;
				ACR_OFF_CV_LO:  s = 3'h5;
				ACR_OFF_CFG:    s = 3'h6;
				default:        s = 3'h7;
			endcase
		end
		return s;
	endfunction

	// bus slave state
	logic                  awready_q;
	logic                  wready_q;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	logic                  arready_q;
	logic                  rvalid_q;
	logic [1:0]            rresp_q;
	logic [ACR_DATA_W-1:0] rdata_q;
	logic [ACR_ADDR_W-1:0] waddr_q;
	logic [7:0]            wbyte_q;
	logic                  wlane_q;
	logic                  aw_full_q;
	logic                  w_full_q;

	// software visible state
	logic                  flag_q;
	logic                  irq_en_q;
	logic                  cont_q;
	logic [4:0]            chan_q;
	logic                  trg_sel_q;
	logic                  cmp_en_q;
	logic                  cmp_ge_q;
	logic [7:0]            cv_hi_q;
	logic [7:0]            cv_lo_q;
	logic [1:0]            mode_q;
	logic [7:0]            res_hi_q;
	logic [7:0]            res_lo_q;
	logic                  lock_q;
	logic                  irq_q;

	// converter control
	acr_state_t            state_q;
	acr_state_t            state_d;
	logic                  start_q;
	logic                  abort_q;
	logic [2:0]            trg_q;

	// decoded events
	logic                  aw_hs;
	logic                  w_hs;
	logic                  ar_hs;
	logic                  wr_go;
	logic [2:0]            wsel;
	logic [2:0]            rsel;
	logic                  wr_en;
	logic                  wr_sc1;
	logic                  wr_sc2;
	logic                  wr_cfg;
	logic                  rd_hi;
	logic                  rd_lo;
	logic [4:0]            new_ch;
	logic                  new_off;
	logic                  trig_edge;
	logic                  conv_done;
	logic                  cmp_hit;
	logic [11:0]           res_val;
	logic                  accept;
	logic                  load_res;
	logic                  interlock;
	logic                  start_d;
	logic                  abort_d;
	logic                  flag_set;
	logic                  flag_clr;
	logic [7:0]            rd_byte;
	logic [7:0]            sc1_rd;
	logic [7:0]            sc2_rd;
	logic [7:0]            cfg_rd;

	assign aw_hs    = s_axi_awvalid & awready_q;
	assign w_hs     = s_axi_wvalid & wready_q;
	assign ar_hs    = s_axi_arvalid & arready_q;
	assign wr_go    = aw_full_q & w_full_q & ~bvalid_q;
	assign wsel     = reg_sel(waddr_q);
	assign rsel     = reg_sel(s_axi_araddr);
	assign wr_en    = wr_go & wlane_q;
	assign wr_sc1   = wr_en & (wsel == 3'h0);
	assign wr_sc2   = wr_en & (wsel == 3'h1);
	assign wr_cfg   = wr_en & (wsel == 3'h6);
	assign rd_hi    = ar_hs & (rsel == 3'h2);
	assign rd_lo    = ar_hs & (rsel == 3'h3);
	assign new_ch   = wbyte_q[ACR_SC1_CH_HI:ACR_SC1_CH_LO];
	assign new_off  = new_ch == ACR_CH_OFF;

	// trigger pin: two-stage synchroniser, then rising edge
	assign trig_edge = trg_q[1] & ~trg_q[2];
	// a done that coincides with a restarting write belongs to the aborted run
	assign conv_done = conv_rsp.done & (state_q == ACR_S_CONV) & ~wr_sc1;

	acr_compare u_cmp (
		.mode    (mode_q),
		.raw     (conv_rsp.result),
		.cv_high (cv_hi_q),
		.cv_low  (cv_lo_q),
		.ge_sel  (cmp_ge_q),
		.result  (res_val),
		.hit     (cmp_hit)
	);

	// result accepted when compare off or compare true
	assign accept    = conv_done & (~cmp_en_q | cmp_hit);
	// high read locks loads in every mode but 8-bit
	assign interlock = lock_q & (mode_q != ACR_MODE_8);
	assign load_res  = accept & ~interlock;
	assign flag_set  = accept;
	assign flag_clr  = wr_sc1 | rd_lo;

	// conversion sequencer
	always_comb begin
		state_d = state_q;
		start_d = 1'b0;
		abort_d = 1'b0;
		if (wr_sc1) begin
			abort_d = state_q == ACR_S_CONV;
			if (new_off) begin
				state_d = ACR_S_OFF;
			end else if (!trg_sel_q) begin
				state_d = ACR_S_CONV;
				start_d = 1'b1;
			end else begin
				state_d = ACR_S_IDLE;
			end
		end else begin
			unique case (state_q)
				ACR_S_OFF: begin
					state_d = ACR_S_OFF;
				end
				ACR_S_IDLE: begin
					if (trg_sel_q && trig_edge) begin
						state_d = ACR_S_CONV;
						start_d = 1'b1;
					end
				end
				ACR_S_CONV: begin
					if (conv_done && cont_q) begin
						start_d = 1'b1;
					end else if (conv_done) begin
						state_d = ACR_S_IDLE;
					end
				end
				default: begin
					state_d = ACR_S_OFF;
				end
			endcase
		end
	end

	// read data select; reserved bits read zero
	assign sc1_rd = {flag_q, irq_en_q, cont_q, chan_q};
	assign sc2_rd = {state_q == ACR_S_CONV, trg_sel_q, cmp_en_q,
	                 cmp_ge_q, 4'h0};
	assign cfg_rd = {4'h0, mode_q, 2'h0};
	assign rd_byte = (rsel == 3'h0) ? sc1_rd :
	                 (rsel == 3'h1) ? sc2_rd :
	                 (rsel == 3'h2) ? res_hi_q :
	                 (rsel == 3'h3) ? res_lo_q :
	                 (rsel == 3'h4) ? cv_hi_q :
	                 (rsel == 3'h5) ? cv_lo_q :
	                 (rsel == 3'h6) ? cfg_rd : 8'h00;

	// write address and data holding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			waddr_q   <= '0;
			wbyte_q   <= 8'h00;
			wlane_q   <= 1'b0;
		end else begin
			if (aw_hs) begin
				awready_q <= 1'b0;
				aw_full_q <= 1'b1;
				waddr_q   <= s_axi_awaddr;
			end
			if (w_hs) begin
				wready_q <= 1'b0;
				w_full_q <= 1'b1;
				wbyte_q  <= s_axi_wdata[7:0];
				wlane_q  <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				awready_q <= 1'b1;
				wready_q  <= 1'b1;
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
			end
		end
	end

	// write response and read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q  <= 1'b0;
			bresp_q   <= ACR_RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= ACR_RESP_OKAY;
			rdata_q   <= '0;
		end else begin
			if (wr_go) begin
				bvalid_q <= 1'b1;
				bresp_q  <= (wsel == 3'h7) ? ACR_RESP_SLVERR : ACR_RESP_OKAY;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (ar_hs) begin
				arready_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rresp_q   <= (rsel == 3'h7) ? ACR_RESP_SLVERR : ACR_RESP_OKAY;
				rdata_q   <= {24'h000000, rd_byte};
			end else if (rvalid_q && s_axi_rready) begin
				arready_q <= 1'b1;
				rvalid_q  <= 1'b0;
			end
		end
	end

	// control and compare registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en_q  <= ACR_SC1_RST[ACR_SC1_IEN];
			cont_q    <= ACR_SC1_RST[ACR_SC1_CONT];
			chan_q    <= ACR_SC1_RST[ACR_SC1_CH_HI:ACR_SC1_CH_LO];
			trg_sel_q <= ACR_SC2_RST[ACR_SC2_TRG];
			cmp_en_q  <= ACR_SC2_RST[ACR_SC2_CMPEN];
			cmp_ge_q  <= ACR_SC2_RST[ACR_SC2_GE];
			cv_hi_q   <= ACR_CV_RST;
			cv_lo_q   <= ACR_CV_RST;
			mode_q    <= ACR_MODE_RST;
		end else begin
			if (wr_sc1) begin
				irq_en_q <= wbyte_q[ACR_SC1_IEN];
				cont_q   <= wbyte_q[ACR_SC1_CONT];
				chan_q   <= new_ch;
			end
			// bits 3:0 are not stored; software keeps them zero
			if (wr_sc2) begin
				trg_sel_q <= wbyte_q[ACR_SC2_TRG];
				cmp_en_q  <= wbyte_q[ACR_SC2_CMPEN];
				cmp_ge_q  <= wbyte_q[ACR_SC2_GE];
			end
			if (wr_en && wsel == 3'h4) begin
				cv_hi_q <= wbyte_q;
			end
			if (wr_en && wsel == 3'h5) begin
				cv_lo_q <= wbyte_q;
			end
			// stale results are left as they are after this
			if (wr_cfg) begin
				mode_q <= wbyte_q[ACR_CFG_MODE_HI:ACR_CFG_MODE_LO];
			end
		end
	end

	// results, interlock, flag and interrupt
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_hi_q <= ACR_RES_RST;
			res_lo_q <= ACR_RES_RST;
			lock_q   <= 1'b0;
			flag_q   <= 1'b0;
			irq_q    <= 1'b0;
		end else begin
			if (load_res) begin
				res_hi_q <= {4'h0, res_val[11:8]};
				res_lo_q <= res_val[7:0];
			end
			if (rd_lo) begin
				lock_q <= 1'b0;
			end else if (rd_hi && mode_q != ACR_MODE_8) begin
				lock_q <= 1'b1;
			end
			// a set in the clearing cycle wins
			flag_q <= flag_set | (flag_q & ~flag_clr);
			irq_q  <= (flag_set | (flag_q & ~flag_clr)) &
			          (wr_sc1 ? wbyte_q[ACR_SC1_IEN] : irq_en_q);
		end
	end

	// sequencer state, strobes and trigger synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= ACR_S_OFF;
			start_q <= 1'b0;
			abort_q <= 1'b0;
			trg_q   <= 3'h0;
		end else begin
			state_q <= state_d;
			start_q <= start_d;
			abort_q <= abort_d;
			trg_q   <= {trg_q[1:0], hw_trigger_in};
		end
	end

	assign s_axi_awready    = awready_q;
	assign s_axi_wready     = wready_q;
	assign s_axi_bvalid     = bvalid_q;
	assign s_axi_bresp      = bresp_q;
	assign s_axi_arready    = arready_q;
	assign s_axi_rvalid     = rvalid_q;
	assign s_axi_rresp      = rresp_q;
	assign s_axi_rdata      = rdata_q;
	assign conv_req.start   = start_q;
	assign conv_req.abort   = abort_q;
	// converter powered only while converting
	assign conv_req.powered = state_q == ACR_S_CONV;
	assign conv_req.channel = chan_q;
	assign conv_req.mode    = mode_q;
	assign complete_irq     = irq_q;
endmodule

// ==== rtl/acr_pkg.sv ====
// shared constants, encodings and carrier types of the converter control block
package acr_pkg;

	localparam int         ACR_DATA_W     = 32;
	localparam int         ACR_ADDR_W     = 8;
	localparam int         ACR_RES_W      = 12;
	localparam int         ACR_CH_W       = 5;

	// register byte offsets
	localparam logic [7:0] ACR_OFF_SC1    = 8'h00;
	localparam logic [7:0] ACR_OFF_SC2    = 8'h04;
	localparam logic [7:0] ACR_OFF_RES_HI = 8'h08;
	localparam logic [7:0] ACR_OFF_RES_LO = 8'h0c;
	localparam logic [7:0] ACR_OFF_CV_HI  = 8'h10;
	localparam logic [7:0] ACR_OFF_CV_LO  = 8'h14;
	localparam logic [7:0] ACR_OFF_CFG    = 8'h18;

	// status/control one fields
	localparam int         ACR_SC1_FLAG   = 7;
	localparam int         ACR_SC1_IEN    = 6;
	localparam int         ACR_SC1_CONT   = 5;
	localparam int         ACR_SC1_CH_HI  = 4;
	localparam int         ACR_SC1_CH_LO  = 0;

	// status/control two fields
	localparam int         ACR_SC2_ACT    = 7;
	localparam int         ACR_SC2_TRG    = 6;
	localparam int         ACR_SC2_CMPEN  = 5;
	localparam int         ACR_SC2_GE     = 4;

	// configuration: resolution field
	localparam int         ACR_CFG_MODE_HI = 3;
	localparam int         ACR_CFG_MODE_LO = 2;

	// reset values
	localparam logic [7:0] ACR_SC1_RST    = 8'h1f;
	localparam logic [7:0] ACR_SC2_RST    = 8'h00;
	localparam logic [7:0] ACR_CV_RST     = 8'h00;
	localparam logic [7:0] ACR_RES_RST    = 8'h00;
	localparam logic [1:0] ACR_MODE_RST   = 2'h0;

	// channel codes
	localparam logic [4:0] ACR_CH_LAST_AD = 5'h1b;
	localparam logic [4:0] ACR_CH_RSVD    = 5'h1c;
	localparam logic [4:0] ACR_CH_REFH    = 5'h1d;
	localparam logic [4:0] ACR_CH_REFL    = 5'h1e;
	localparam logic [4:0] ACR_CH_OFF     = 5'h1f;

	// resolution codes
	localparam logic [1:0] ACR_MODE_8     = 2'h0;
	localparam logic [1:0] ACR_MODE_12    = 2'h1;
	localparam logic [1:0] ACR_MODE_10    = 2'h2;
	localparam logic [1:0] ACR_MODE_RSVD  = 2'h3;

	localparam logic [11:0] ACR_MASK_8    = 12'h0ff;
	localparam logic [11:0] ACR_MASK_10   = 12'h3ff;
	localparam logic [11:0] ACR_MASK_12   = 12'hfff;

	localparam logic [1:0] ACR_RESP_OKAY  = 2'h0;
	localparam logic [1:0] ACR_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ACR_S_OFF  = 3'b001,
		ACR_S_IDLE = 3'b010,
		ACR_S_CONV = 3'b100
	} acr_state_t;

	// request to the analog converter
	typedef struct packed {
		logic       start;
		logic       abort;
		logic       powered;
		logic [4:0] channel;
		logic [1:0] mode;
	} acr_conv_req_t;

	// answer from the analog converter
	typedef struct packed {
		logic        done;
		logic [11:0] result;
	} acr_conv_rsp_t;

endpackage

// ==== rtl/acr_compare.sv ====
// resolution masking and automatic compare of one finished conversion
`timescale 1ns/1ns
module acr_compare
	import acr_pkg::*;
(
	input  wire logic [1:0]  mode,
	input  wire logic [11:0] raw,
	input  wire logic [7:0]  cv_high,
	input  wire logic [7:0]  cv_low,
	input  wire logic        ge_sel,
	output logic      [11:0] result,
	output logic             hit
);
	logic [11:0] mask;
	logic [11:0] cv_full;
	logic        less;

	// unused high bits of the active width read zero
	assign mask    = (mode == ACR_MODE_8)  ? ACR_MASK_8 :
	                 (mode == ACR_MODE_10) ? ACR_MASK_10 : ACR_MASK_12;
	assign result  = raw & mask;
	// high compare byte drops out in 8-bit mode
	assign cv_full = {cv_high[3:0], cv_low} & mask;
	// unsigned compare at the active width
	assign less    = result < cv_full;
	// direction select
	assign hit     = ge_sel ? ~less : less;
endmodule

// ==== tb/acr_conv_model.sv ====
// behavioural converter: answers a start after a chosen latency unless an abort or a later start cuts it short
`timescale 1ns/1ns
module acr_conv_model
	import acr_pkg::*;
(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire acr_conv_req_t conv_req,
	input  wire logic [11:0]   value,
	input  wire logic [3:0]    lat,
	output acr_conv_rsp_t      conv_rsp
);
	logic [4:0] cnt_q;

	always_ff @(posedge aclk) begin
		conv_rsp.done <= 1'b0;
		conv_rsp.result <= ~conv_rsp.result;
		if (!aresetn) begin
			cnt_q <= 5'h00;
			conv_rsp.result <= 12'h000;
		end else if (conv_req.start) begin
			cnt_q <= {1'b0, lat} + 5'h01;
		end else if (conv_req.abort) begin
			cnt_q <= 5'h00;
		end else if (cnt_q == 5'h01) begin
			cnt_q <= 5'h00;
			conv_rsp.done <= 1'b1;
			conv_rsp.result <= value;
		end else if (cnt_q != 5'h00) begin
			cnt_q <= cnt_q - 5'h01;
		end
	end
endmodule

// ==== tb/acr_top_monitor.sv ====
// concurrent checks on the converter control ports
`timescale 1ns/1ns
module acr_top_monitor
	import acr_pkg::*;
(
	input wire logic          aclk,
	input wire logic          aresetn,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic          s_axi_bvalid,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic          s_axi_rvalid,
	input wire logic [31:0]   s_axi_rdata,
	input wire acr_conv_req_t conv_req,
	input wire acr_conv_rsp_t conv_rsp,
	input wire logic          complete_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready;

	a_write_answer: assert property (wr_take |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read late");
	a_rdata_upper: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:8] == 24'h000000) else $error("rdata high");
	a_start_pulse: assert property (conv_req.start
		|-> conv_req.powered ##1 !conv_req.start) else $error("start");
	a_off_idle: assert property (conv_req.channel == ACR_CH_OFF
		|-> !conv_req.start) else $error("start while off");
	a_off_power: assert property ((conv_req.channel == ACR_CH_OFF) [*2]
		|-> !conv_req.powered) else $error("powered while off");
	a_irq_cause: assert property ($rose(complete_irq)
		|-> $past(conv_rsp.done) || $past(conv_rsp.done, 2)
		|| s_axi_bvalid || $past(s_axi_bvalid)) else $error("irq rise");
	a_irq_clear: assert property ($fell(complete_irq)
		|-> s_axi_bvalid || $past(s_axi_bvalid) || s_axi_rvalid
		|| $past(s_axi_rvalid)) else $error("irq fall");

	c_irq: cover property ($rose(complete_irq));
	c_abort: cover property (conv_req.abort);
	c_idle: cover property ($fell(conv_req.powered));
endmodule

// ==== tb/acr_top_tb.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ns
module acr_top_tb
	import acr_pkg::*;
;
	logic          aclk = 1'b0;
	logic          aresetn;
	logic [7:0]    awaddr, araddr;
	logic [31:0]   wdata, rdata;
	logic          awvalid, awready, wvalid, wready, bvalid, bready;
	logic          arvalid, arready, rvalid, rready, hw, irq;
	logic [1:0]    bresp, rresp;
	logic [11:0]   value;
	logic [3:0]    lat;
	acr_conv_req_t conv_req;
	acr_conv_rsp_t conv_rsp;
	int            n_errors, check_count, n_start, n_abort, ns;
	logic [4:0]    chs [4] = '{5'h00, 5'h1b, 5'h1d, 5'h1e};

	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		n_start <= n_start + int'(conv_req.start);
		n_abort <= n_abort + int'(conv_req.abort);
	end

	acr_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .hw_trigger_in(hw),
		.conv_rsp(conv_rsp), .conv_req(conv_req), .complete_irq(irq));
	acr_conv_model u_conv (.aclk(aclk), .aresetn(aresetn),
		.conv_req(conv_req), .value(value), .lat(lat), .conv_rsp(conv_rsp));

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int         t;
		logic       aw, w;
		logic [1:0] r;
		aw = 1'b1;
		w = 1'b1;
		r = 2'h3;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (t = 0; t < 50; t++) begin
			@(posedge aclk);
			if (!aw && !w && bvalid) begin
				r = bresp;
				break;
			end
			if (awready) aw = 1'b0;
			if (wready) w = 1'b0;
			awvalid <= aw;
			wvalid <= w;
		end
		if (r == 2'h3) begin
			awvalid <= 1'b0;
			wvalid <= 1'b0;
		end
		bready <= 1'b0;
		// let an edge pass so the next call does not re-drive in this step
		@(posedge aclk);
		chk(r, (a > ACR_OFF_CFG) ? ACR_RESP_SLVERR : ACR_RESP_OKAY);
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		int          t;
		logic [31:0] d;
		logic [1:0]  r;
		d = 32'hffffffff;
		r = 2'h3;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (t = 0; t < 50; t++) begin
			@(posedge aclk);
			if (rvalid) begin
				d = rdata;
				r = rresp;
				break;
			end
			if (arready) arvalid <= 1'b0;
		end
		if (r == 2'h3) begin
			arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge aclk);
		chk(d, {24'h000000, e});
		chk(r, (a > ACR_OFF_CFG) ? ACR_RESP_SLVERR : ACR_RESP_OKAY);
	endtask

	task automatic wdone;
		int t;
		for (t = 0; t < 200 && !conv_rsp.done; t++) begin
			@(posedge aclk);
		end
		chk(conv_rsp.done, 1'b1);
		repeat (2) @(posedge aclk);
	endtask

	task automatic conv(input logic [11:0] v, input logic [7:0] s);
		value <= v;
		wr(ACR_OFF_SC1, s);
		wdone;
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#200000;
		n_errors++;
		complete_run;
	end

	initial begin
		{aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
		{arvalid, rready, hw, value} = '0;
		lat = 4'h2;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(ACR_OFF_SC1, ACR_SC1_RST);
		rc(ACR_OFF_SC2, 8'h00);
		rc(ACR_OFF_RES_LO, 8'h00);
		rc(ACR_OFF_CV_HI, 8'h00);
		rc(8'h1c, 8'h00);
		wr(8'h20, 8'hff);
		$display("test reset done");
		wr(ACR_OFF_CFG, 8'h04);
		ns = n_start;
		conv(12'habc, 8'h43);
		repeat (10) @(posedge aclk);
		chk(n_start, ns + 1);
		chk(conv_req.channel, 5'h03);
		chk(conv_req.mode, ACR_MODE_12);
		chk(conv_req.powered, 1'b0);
		chk(irq, 1'b1);
		rc(ACR_OFF_SC1, 8'hc3);
		rc(ACR_OFF_RES_HI, 8'h0a);
		rc(ACR_OFF_RES_LO, 8'hbc);
		rc(ACR_OFF_SC1, 8'h43);
		chk(irq, 1'b0);
		foreach (chs[i]) begin
			conv(12'h001, {3'h0, chs[i]});
			chk(conv_req.channel, chs[i]);
		end
		$display("test single done");
		lat = 4'hc;
		ns = n_abort;
		value <= 12'h123;
		wr(ACR_OFF_SC1, 8'h03);
		rc(ACR_OFF_SC2, 8'h80);
		wr(ACR_OFF_SC1, 8'h03);
		wdone;
		chk(n_abort > ns, 1'b1);
		rc(ACR_OFF_SC2, 8'h00);
		lat = 4'h2;
		rc(ACR_OFF_RES_HI, 8'h01);
		conv(12'h456, 8'h03);
		rc(ACR_OFF_RES_LO, 8'h23);
		rc(ACR_OFF_RES_HI, 8'h01);
		wr(ACR_OFF_CFG, 8'h00);
		conv(12'hfab, 8'h03);
		rc(ACR_OFF_RES_HI, 8'h00);
		conv(12'h0cd, 8'h03);
		rc(ACR_OFF_RES_LO, 8'hcd);
		wr(ACR_OFF_CFG, 8'h08);
		conv(12'hfff, 8'h03);
		rc(ACR_OFF_RES_HI, 8'h03);
		rc(ACR_OFF_RES_LO, 8'hff);
		$display("test result done");
		wr(ACR_OFF_CFG, 8'h04);
		wr(ACR_OFF_CV_HI, 8'h02);
		wr(ACR_OFF_CV_LO, 8'h00);
		wr(ACR_OFF_SC2, 8'h20);
		conv(12'h1ff, 8'h03);
		rc(ACR_OFF_SC1, 8'h83);
		rc(ACR_OFF_RES_HI, 8'h01);
		rc(ACR_OFF_RES_LO, 8'hff);
		conv(12'h300, 8'h03);
		rc(ACR_OFF_SC1, 8'h03);
		rc(ACR_OFF_RES_LO, 8'hff);
		wr(ACR_OFF_SC2, 8'h30);
		conv(12'h200, 8'h03);
		rc(ACR_OFF_SC1, 8'h83);
		rc(ACR_OFF_RES_HI, 8'h02);
		rc(ACR_OFF_RES_LO, 8'h00);
		wr(ACR_OFF_CFG, 8'h00);
		wr(ACR_OFF_CV_LO, 8'h10);
		conv(12'h010, 8'h03);
		rc(ACR_OFF_SC1, 8'h83);
		$display("test compare done");
		wr(ACR_OFF_SC2, 8'h40);
		ns = n_start;
		wr(ACR_OFF_SC1, 8'h45);
		repeat (20) @(posedge aclk);
		chk(n_start, ns);
		hw <= 1'b1;
		wdone;
		hw <= 1'b0;
		chk(n_start, ns + 1);
		chk(irq, 1'b1);
		wr(ACR_OFF_SC2, 8'h00);
		$display("test trigger done");
		ns = n_start;
		wr(ACR_OFF_SC1, 8'h23);
		repeat (40) @(posedge aclk);
		chk(n_start > ns + 3, 1'b1);
		wr(ACR_OFF_SC1, 8'h3f);
		repeat (2) @(posedge aclk);
		ns = n_start;
		repeat (20) @(posedge aclk);
		chk(n_start, ns);
		chk(conv_req.powered, 1'b0);
		$display("test continuous done");
		complete_run;
	end
endmodule

bind acr_top acr_top_monitor u_mon (.*);
